/* hdl/port_pins.sv */
// port_pins: analog-capable input port and shared-function port
// Functional notes
// (R1) analog bit 0: port0 data read returns the live pin level
// (R2) analog bit 1: port0 data bit reads as 1
// (R3) analog bit selects digital input or converter analog channel per pin
// (R4) port0 pins off in reset/standby/watch/subactive, held in sleep
// (R5) port1: four bidirectional pins, one input-only, one high-voltage input
// (R6) function register resets to 0x0C, all shared pins general, filter off
// (R7) function bit 7 turns the int0 noise filter on
// (R8) int0 filter is off in standby, watch and subactive modes
// (R9) filter samples int0, disagreeing successive samples count as noise
// (R10) function bit 6 routes input pin 6 to the event timer input
// (R11) reading port1 data may advance the event counter
// (R12) software clears the event counter before trusting the count
// (R13) function bit 5 picks int5 input, else general pin or wave output
// (R14) function bit 4 picks general pin or int4 input
// (R15) software masks interrupts around pin function changes
// (R16) function bits 3 and 2 are fixed at 1, not writable
// (R17) direction bit 1 makes a pin an output, 0 an input
// (R18) shared pins feed their level to the selected interrupt or timer
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
module port_pins import port_pkg::*; #(
  parameter int SAMPLE_DIV = NOISE_SAMPLE_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire power_mode_t power_mode,
  input wire logic [7:0] port0_pin_levels,
  output logic [7:0] port0_input_en,
  output logic [7:0] analog_channel_select,
  input wire logic [3:0] port1_pin_in,
  output logic [3:0] port1_pin_out,
  output logic [3:0] port1_pin_oe,
  input wire logic port1_pin6_in,
  input wire logic port1_pin7_in,
  input wire logic timer_wave_in,
  output logic int0_level,
  output logic int1_level,
  output logic int4_level,
  output logic int5_level,
  output logic event_level,
  output logic event_read_pulse
);
  typedef struct packed {
    logic run;
    logic [7:0] analog_sel;
    logic [7:0] func;
    logic [3:0] dir;
    logic [3:0] data;
    logic [7:4] wave;
    logic [7:0] p0_level;
    logic wr_pend;
    logic [15:0] wr_idx;
    logic [31:0] rdata;
    logic [3:0] pout;
    logic [3:0] poe;
    logic ev_read;
  } port_state_t;

  port_state_t s_q, s_d;
  logic acc;
  logic [15:0] acc_idx;
  logic [31:0] rd_mux;
  logic [7:0] p1_read;
  logic pins_live;
  logic low_power;
  logic filter_on;
  logic tick;
  logic int0_filtered;
  logic [3:0] p1_pin_val;

  assign acc = hsel && hready && htrans == HTRANS_NONSEQ;
  assign acc_idx = haddr[17:2];
  assign pins_live = power_mode == PM_ACTIVE || power_mode == PM_SLEEP;
  assign low_power = power_mode == PM_STANDBY || power_mode == PM_WATCH ||
                     power_mode == PM_SUBACTIVE;
  assign filter_on = s_q.func[FN_NOISE] && !low_power; // [R7] [R8]

  // output pins read back the latch, input pins the pad
  assign p1_pin_val = (s_q.dir & s_q.data) | (~s_q.dir & port1_pin_in);
  assign p1_read = {port1_pin7_in, port1_pin6_in, p1_pin_val[SL5],
                    p1_pin_val[SL4], 2'b00, p1_pin_val[SL1],
                    p1_pin_val[SL0]} | DATA_FIXED; // [R5]

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (acc_idx)
      IDX_PORT0_LEVELS: begin
        rd_mux = {24'h000000, s_q.p0_level | s_q.analog_sel}; // [R1] [R2]
      end
      IDX_PORT1_DATA: begin
        rd_mux = {24'h000000, p1_read};
      end
      IDX_PORT1_FUNC: begin
        rd_mux = {24'h000000, s_q.func | FUNC_FIXED}; // [R16]
      end
      IDX_WAVE_SEL: begin
        rd_mux = {24'h000000, s_q.wave, 4'h0} | {24'h000000, WAVE_FIXED};
      end
      IDX_PORT1_DIR, IDX_ANALOG_SEL: begin
        // write-only registers give no state back
        rd_mux = WO_READ;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.run = 1'b1;
    s_d.ev_read = 1'b0;
    s_d.wr_pend = acc && hwrite;
    s_d.wr_idx = acc_idx;
    if (acc && !hwrite) begin
      s_d.rdata = rd_mux;
      // a data read strobes the event pin only while pin 6 is a general input
      s_d.ev_read = acc_idx == IDX_PORT1_DATA && !s_q.func[FN_EVENT];
    end // [R11]
    if (s_q.wr_pend) begin
      case (s_q.wr_idx)
        IDX_ANALOG_SEL: begin
          s_d.analog_sel = hwdata[7:0];
        end
        IDX_PORT1_FUNC: begin
          s_d.func = hwdata[7:0] | FUNC_FIXED; // [R16]
        end
        IDX_PORT1_DIR: begin
          s_d.dir = {hwdata[5], hwdata[4], hwdata[1], hwdata[0]};
        end
        IDX_PORT1_DATA: begin
          s_d.data = {hwdata[5], hwdata[4], hwdata[1], hwdata[0]};
        end
        IDX_WAVE_SEL: begin
          s_d.wave = hwdata[7:4];
        end
        default: begin
          s_d.wave = s_q.wave;
        end
      endcase
    end
    // sleep and deeper modes freeze the sampled levels
    if (power_mode == PM_ACTIVE) begin
      s_d.p0_level = port0_pin_levels;
    end // [R4]
    // pins given to an interrupt are released [R13] [R14]
    s_d.poe = s_q.dir & ~{s_q.func[FN_INT5], s_q.func[FN_INT4],
                          s_q.func[FN_INT1], s_q.func[FN_INT0]}; // [R17]
    s_d.pout = s_q.data;
    if (!s_q.func[FN_INT5] && s_q.wave[WV_OUT_SEL]) begin
      s_d.poe[SL5] = 1'b1;
      s_d.pout[SL5] = s_q.wave[WV_OUT_ON] && timer_wave_in; // [R13]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.run <= 1'b0;
      s_q.analog_sel <= ANALOG_SEL_RESET;
      s_q.func <= FUNC_RESET; // [R6]
      s_q.dir <= {DIR_RESET[5], DIR_RESET[4], DIR_RESET[1], DIR_RESET[0]};
      s_q.data <= DATA_RESET;
      s_q.wave <= WAVE_RESET[7:4];
      s_q.p0_level <= 8'h00;
      s_q.wr_pend <= 1'b0;
      s_q.wr_idx <= 16'h0000;
      s_q.rdata <= 32'h0000_0000;
      s_q.pout <= 4'h0;
      s_q.poe <= 4'h0;
      s_q.ev_read <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  tick_divider #(.DIV(SAMPLE_DIV)) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  noise_filter u_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(filter_on),
    .sample_en(tick),
    .raw(port1_pin_in[SL0]),
    .filtered(int0_filtered)
  ); // [R9]

  // unselected interrupt inputs idle high (active-low sources)
  assign int0_level = s_q.func[FN_INT0] ? int0_filtered : 1'b1; // [R18]
  assign int1_level = s_q.func[FN_INT1] ? port1_pin_in[SL1] : 1'b1;
  assign int4_level = s_q.func[FN_INT4] ? port1_pin_in[SL4] : 1'b1; // [R14]
  assign int5_level = s_q.func[FN_INT5] ? port1_pin_in[SL5] : 1'b1; // [R13]
  assign event_level = s_q.func[FN_EVENT] ? port1_pin6_in : 1'b1; // [R10]
  assign event_read_pulse = s_q.ev_read; // [R11]

  assign port0_input_en = ~s_q.analog_sel & {8{pins_live && s_q.run}}; // [R3]
  assign analog_channel_select = s_q.analog_sel; // [R3]
  assign port1_pin_out = s_q.pout;
  assign port1_pin_oe = s_q.poe;
  assign hreadyout = 1'b1;
  assign hrdata = s_q.rdata;
  assign hresp = 1'b0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_port0;
    acc && !hwrite && acc_idx == IDX_PORT0_LEVELS;
  endsequence

  property p_analog_one;
    s_rd_port0 |=>
      (hrdata[7:0] & $past(s_q.analog_sel)) == $past(s_q.analog_sel);
  endproperty
  a_analog_one: assert property (p_analog_one) // [R2]
    else $error("analog pin did not read as one");

  property p_digital_level;
    s_rd_port0 |=> (hrdata[7:0] & ~$past(s_q.analog_sel)) ==
                   ($past(s_q.p0_level) & ~$past(s_q.analog_sel));
  endproperty
  a_digital_level: assert property (p_digital_level) // [R1]
    else $error("digital pin read did not return pin level");

  property p_func_reset;
    $rose(s_q.run) |-> s_q.func == FUNC_RESET && s_q.poe == 4'h0;
  endproperty
  a_func_reset: assert property (p_func_reset) // [R6]
    else $error("function register not at reset value");

  property p_fixed_bits;
    s_q.wr_pend && s_q.wr_idx == IDX_PORT1_FUNC |=>
      s_q.func[3:2] == 2'b11 && s_q.func[7:4] == $past(hwdata[7:4]);
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) // [R16]
    else $error("function register write wrong");

  property p_dir_oe;
    !s_q.func[FN_INT4] && $stable(s_q.func) |=> port1_pin_oe[SL4] ==
      $past(s_q.dir[SL4]);
  endproperty
  a_dir_oe: assert property (p_dir_oe) // [R17]
    else $error("pin 4 enable does not follow direction");

  property p_int5_release;
    s_q.func[FN_INT5] ##1 s_q.func[FN_INT5] |-> !port1_pin_oe[SL5];
  endproperty
  a_int5_release: assert property (p_int5_release) // [R13]
    else $error("pin 5 driven while used as interrupt input");

  property p_event_route;
    event_level == (s_q.func[FN_EVENT] ? port1_pin6_in : 1'b1);
  endproperty
  a_event_route: assert property (p_event_route) // [R10]
    else $error("event input routing wrong");

  property p_read_event;
    acc && !hwrite && acc_idx == IDX_PORT1_DATA && !s_q.func[FN_EVENT]
      |=> event_read_pulse ##1 !event_read_pulse || $past(acc);
  endproperty
  a_read_event: assert property (p_read_event) // [R11]
    else $error("port 1 read gave no event strobe");

  property p_low_power_off;
    low_power |-> port0_input_en == 8'h00 && (!s_q.func[FN_INT0] ||
                  int0_level == port1_pin_in[SL0]);
  endproperty
  a_low_power_off: assert property (p_low_power_off) // [R4] [R8]
    else $error("pins or filter active in a low-power mode");

  property p_sleep_hold;
    power_mode == PM_SLEEP |=> $stable(s_q.p0_level);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) // [R4]
    else $error("port 0 level changed in sleep");
endmodule

/* hdl/port_pkg.sv */
// package: register indices, field positions, reset values, modes
package port_pkg;
  // printed offsets are not word multiples: they are indices, byte addr = 4x
  localparam logic [15:0] IDX_PORT0_LEVELS = 16'hFFD0;
  localparam logic [15:0] IDX_PORT1_DATA = 16'hFFD1;
  localparam logic [15:0] IDX_PORT1_DIR = 16'hFFE1;
  localparam logic [15:0] IDX_PORT1_FUNC = 16'hFFEB;
  localparam logic [15:0] IDX_WAVE_SEL = 16'hFFEE;
  localparam logic [15:0] IDX_ANALOG_SEL = 16'hFFEF;

  localparam logic [7:0] ANALOG_SEL_RESET = 8'h00;
  localparam logic [7:0] FUNC_RESET = 8'h0C;
  localparam logic [7:0] DIR_RESET = 8'hCC;
  localparam logic [7:0] WAVE_RESET = 8'h0F;
  localparam logic [3:0] DATA_RESET = 4'h0;

  // fixed-one masks of reserved bits
  localparam logic [7:0] FUNC_FIXED = 8'h0C;
  localparam logic [7:0] DIR_FIXED = 8'hCC;
  localparam logic [7:0] DATA_FIXED = 8'h0C;
  localparam logic [7:0] WAVE_FIXED = 8'h0F;
  localparam logic [31:0] WO_READ = 32'h0000_00FF;

  // function register fields
  localparam int FN_NOISE = 7;
  localparam int FN_EVENT = 6;
  localparam int FN_INT5 = 5;
  localparam int FN_INT4 = 4;
  localparam int FN_INT1 = 1;
  localparam int FN_INT0 = 0;
  // waveform select fields
  localparam int WV_OUT_SEL = 7;
  localparam int WV_OUT_ON = 6;
  // pins 5,4,1,0 of port 1 sit at local slots 3..0
  localparam int SL5 = 3;
  localparam int SL4 = 2;
  localparam int SL1 = 1;
  localparam int SL0 = 0;

  // sampling interval of the int0 filter is not fixed by the part
  localparam int NOISE_SAMPLE_DIV = 16;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [2:0] {
    PM_ACTIVE,
    PM_SLEEP,
    PM_STANDBY,
    PM_WATCH,
    PM_SUBACTIVE
  } power_mode_t;
endpackage

/* hdl/tick_divider.sv */
// tick_divider: one-cycle enable pulse every DIV clocks
`timescale 1ns/10ps
module tick_divider import port_pkg::*; #(
  parameter int DIV = NOISE_SAMPLE_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } div_state_t;
  localparam logic [15:0] LAST = 16'(DIV - 1);
  div_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = (s_q.cnt == LAST);
    s_d.cnt = s_d.tick ? 16'h0000 : s_q.cnt + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

/* hdl/noise_filter.sv */
// noise_filter: two-sample agreement filter for interrupt input 0
`timescale 1ns/10ps
module noise_filter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic sample_en,
  input wire logic raw,
  output logic filtered
);
  typedef struct packed {
    logic prev;
    logic held;
  } nf_state_t;
  nf_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d.prev = raw;
      s_d.held = raw;
    end else if (sample_en) begin
      s_d.prev = raw;
      // disagreeing samples are noise: keep the old level [R9]
      if (raw == s_q.prev) begin
        s_d.held = raw;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  // bypass when off so the pin is never delayed
  assign filtered = enable ? s_q.held : raw;

  property p_noise_reject;
    @(posedge hclk) disable iff (!hresetn)
      (enable && sample_en && raw != s_q.prev) |=> $stable(s_q.held);
  endproperty
  a_noise_reject: assert property (p_noise_reject) // [R9]
    else $error("filter took a level from disagreeing samples");

  property p_noise_accept;
    @(posedge hclk) disable iff (!hresetn)
      (enable && sample_en && raw == s_q.prev) ##1 enable
        |-> filtered == $past(raw);
  endproperty
  a_noise_accept: assert property (p_noise_accept) // [R9]
    else $error("filter missed two agreeing samples");
endmodule

/* tb/pin_env.sv */
// pin_env: pads and peripheral sources around the port block
`timescale 1ns/10ps
module pin_env (
  input wire logic hclk,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] ext_drive,
  output logic [3:0] pad,
  output logic wave
);
  // a released pad follows the outside source, never the last driven value
  assign pad = (pin_oe & pin_out) | (~pin_oe & ext_drive);
  // toggles every clock so a stale sample of it shows up
  initial begin
    wave = 1'b0;
    forever @(posedge hclk) wave <= ~wave;
  end
endmodule

/* tb/tb_port_pins.sv */
// tb_port_pins: self-checking bench for the port block over the bus
`timescale 1ns/10ps
module tb_port_pins import port_pkg::*; ;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  power_mode_t power_mode;
  logic [7:0] p0_lv, in_en, an_sel, wd, fn;
  logic [3:0] pad, p1_out, p1_oe, ext, dr, dt;
  logic pin6, pin7, wave, int0, int1, int4, int5, ev, ev_pulse, seen;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_ev = 0; // strobe count starts cleared
  int exp_ev = 0;
  int seed;

  // short sample interval keeps the filter runs brief
  port_pins #(.SAMPLE_DIV(2)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .power_mode(power_mode), .port0_pin_levels(p0_lv),
    .port0_input_en(in_en), .analog_channel_select(an_sel),
    .port1_pin_in(pad), .port1_pin_out(p1_out), .port1_pin_oe(p1_oe),
    .port1_pin6_in(pin6), .port1_pin7_in(pin7), .timer_wave_in(wave),
    .int0_level(int0), .int1_level(int1), .int4_level(int4),
    .int5_level(int5), .event_level(ev), .event_read_pulse(ev_pulse)
  );
  pin_env env (
    .hclk(hclk), .pin_oe(p1_oe), .pin_out(p1_out), .ext_drive(ext),
    .pad(pad), .wave(wave)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) if (ev_pulse === 1'b1) n_ev++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask
  // one-cycle low pulse on int0's pin, watched for a few cycles after
  task automatic glitch(output logic s);
    s = 1'b0;
    ext[0] <= 1'b0;
    @(negedge hclk);
    if (int0 === 1'b0) s = 1'b1;
    @(posedge hclk);
    ext[0] <= 1'b1;
    // last edge left free so the next glitch may pull low on it
    repeat (6) begin
      @(negedge hclk);
      if (int0 === 1'b0) s = 1'b1;
      @(posedge hclk);
    end
  endtask
  function automatic logic [3:0] sl(input logic [7:0] b);
    return {b[5], b[4], b[1], b[0]};
  endfunction
  function automatic logic [7:0] p1_exp();
    logic [3:0] v;
    v = (dr & dt) | (~dr & ext);
    return {pin7, pin6, v[3], v[2], 2'h3, v[1], v[0]};
  endfunction

  initial begin
    #100us;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    seed = 32'hEF3DBBD0;
    hresetn <= 1'b0;
    hsel <= 1'b0;
    hwrite <= 1'b0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    htrans <= 2'h0;
    hsize <= 3'h2;
    power_mode <= PM_ACTIVE;
    p0_lv <= 8'h0;
    ext <= 4'h0;
    pin6 <= 1'b0;
    pin7 <= 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, IDX_PORT1_FUNC, 8'h0);
    chk(rd, 32'h0C);
    chk(32'({hresp, hreadyout}), 32'h1);
    xfer(1'b0, IDX_WAVE_SEL, 8'h0);
    chk(rd, 32'h0F);
    xfer(1'b0, IDX_PORT1_DIR, 8'h0);
    chk(rd, WO_READ);
    xfer(1'b0, 16'h0123, 8'h0);
    chk(rd, 32'h0);
    // port 0: random analog split against random pad levels
    for (int i = 0; i < 4; i++) begin
      wd = 8'($random(seed));
      xfer(1'b1, IDX_ANALOG_SEL, wd);
      p0_lv <= 8'($random(seed));
      repeat (3) @(posedge hclk);
      xfer(1'b0, IDX_PORT0_LEVELS, 8'h0);
      chk(rd, 32'(p0_lv | wd));
      chk(32'({in_en, an_sel}), 32'({~wd, wd}));
    end
    // port 1: random functions, directions, data and pads
    for (int i = 0; i < 8; i++) begin
      fn = (i == 0) ? 8'hF3 : 8'($random(seed));
      // pins handed to a function stay inputs
      dr = 4'($random(seed)) & ~sl(fn);
      dt = 4'($random(seed));
      xfer(1'b1, IDX_PORT1_FUNC, fn); // pass 0 selects every shared function, later passes a random set
      xfer(1'b1, IDX_PORT1_DIR, {2'h0, dr[3:2], 2'h0, dr[1:0]});
      xfer(1'b1, IDX_PORT1_DATA, {2'h0, dt[3:2], 2'h0, dt[1:0]});
      ext <= 4'($random(seed));
      pin6 <= 1'($random(seed));
      pin7 <= 1'($random(seed));
      repeat (8) @(posedge hclk);
      xfer(1'b0, IDX_PORT1_FUNC, 8'h0);
      chk(rd, 32'(fn | 8'h0C));
      xfer(1'b0, IDX_PORT1_DATA, 8'h0);
      if (!fn[6]) exp_ev++;
      chk(rd, 32'(p1_exp()));
      chk(32'({p1_oe, p1_out & p1_oe}), 32'({dr, dt & dr}));
      chk(32'({int5, int4, int1, int0, ev}), 32'({fn[5] ? ext[3] : 1'b1,
        fn[4] ? ext[2] : 1'b1, fn[1] ? ext[1] : 1'b1,
        fn[0] ? ext[0] : 1'b1, fn[6] ? pin6 : 1'b1}));
    end
    // let the last strobe be counted before looking
    @(posedge hclk);
    chk(32'(n_ev), 32'(exp_ev));
    // int0 filter on, walked through every power mode
    xfer(1'b1, IDX_PORT1_DIR, 8'h0);
    xfer(1'b1, IDX_PORT1_FUNC, 8'h81);
    ext <= 4'hF;
    repeat (8) @(posedge hclk);
    for (int m = 0; m < 5; m++) begin
      power_mode <= power_mode_t'(3'(m));
      glitch(seen);
      chk(32'(seen), 32'(m >= 2));
      chk(32'(in_en), (m < 2) ? {24'h0, ~wd} : 32'h0);
    end
    power_mode <= PM_ACTIVE;
    xfer(1'b1, IDX_PORT1_FUNC, 8'h01);
    glitch(seen);
    chk(32'(seen), 32'h1);
    // waveform output selected but off: pin 5 drives low
    xfer(1'b1, IDX_WAVE_SEL, 8'h80);
    xfer(1'b0, IDX_WAVE_SEL, 8'h0);
    chk(rd, 32'h8F);
    repeat (2) @(posedge hclk);
    chk(32'({p1_oe[3], p1_out[3]}), 32'h2);
    // waveform on: pin 5 follows the timer wave one edge late
    xfer(1'b1, IDX_WAVE_SEL, 8'hC0);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk(32'({p1_oe[3], p1_out[3]}), 32'({1'b1, ~wave}));
    print_verdict();
  end
endmodule
